// ===== hdl/mqfg_pkg.sv
package mqfg_pkg;

  localparam int          NUM_QUEUES         = 4;
  localparam int          CNT_W              = 20;

  localparam logic [4:0]  OFS_CTRL           = 5'h00;
  localparam logic [4:0]  OFS_STATUS         = 5'h04;
  localparam logic [4:0]  OFS_AE_OFFSET      = 5'h08;
  localparam logic [4:0]  OFS_AF_OFFSET      = 5'h0C;
  localparam logic [4:0]  OFS_DEPTH          = 5'h10;

  localparam int          CTRL_MATCH_LSB     = 0;
  localparam int          CTRL_DEFAULTS_BIT  = 2;

  localparam logic [2:0]  CTRL_RST           = 3'h4;
  localparam logic [15:0] AE_OFFSET_RST      = 16'h0010;
  localparam logic [15:0] AF_OFFSET_RST      = 16'h0010;
  localparam logic [15:0] DEPTH_RST          = 16'h0200;

  localparam logic [15:0] DEFAULT_OFFSET_LOW  = 16'h0008;
  localparam logic [15:0] DEFAULT_OFFSET_HIGH = 16'h0080;

  typedef enum logic [1:0] {
    MQFG_M18_18,
    MQFG_M9_9,
    MQFG_M18_9,
    MQFG_M9_18
  } mqfg_match_t;

endpackage : mqfg_pkg

// ===== hdl/mqfg_flag_gen.sv
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module mqfg_flag_gen
  import mqfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        writeEnable,
  input  wire logic [4:0]  writeQueueAddress,
  input  wire logic        writeQueueLoad,
  input  wire logic        readEnable,
  input  wire logic [1:0]  readQueueAddress,
  input  wire logic        readQueueLoad,
  input  wire logic        defaultOffsetSelect,
  input  wire logic        flagBusModeSelect,
  input  wire logic        chainMasterSelect,
  input  wire logic [2:0]  deviceId,
  input  wire logic        fullBusSelectStrobe,
  input  wire logic        fullTokenIn,
  output logic             queueFullN,
  output logic             almostEmptyN,
  output logic             almostFullN,
  output logic      [3:0]  almostEmptyBus,
  output logic      [3:0]  almostFullBus,
  output logic             almostFullBusOe,
  output logic             fullTokenOut
);

  // configuration straps caught while reset is held
  logic             defSel_r;
  logic             busMode_r;
  logic             master_r;
  logic [2:0]       ctrl_r;
  logic [15:0]      aeOfs_r;
  logic [15:0]      afOfs_r;
  logic [15:0]      depth_r;
  logic             ack_r;
  logic [31:0]      readdata_r;
  logic [1:0]       wrQ_r;
  logic [1:0]       rdQ_r;
  logic [CNT_W-1:0] occ_r   [NUM_QUEUES];
  logic [CNT_W-1:0] occ_nxt [NUM_QUEUES];
  logic [3:0]       shared_r;
  logic [3:0]       aeRaw;
  logic [3:0]       afRaw;
  logic [3:0]       fullRaw;
  logic [3:0]       fullNxt;
  logic [3:0]       aeDly_r;
  logic [3:0]       aeBus_r;
  logic [3:0]       afDly_r;
  logic [3:0]       afBus_r;
  logic             fullN_r;
  logic             ownAddr_r;
  logic             ownTok_r;
  logic             tokFirst_r;
  mqfg_match_t      match;
  logic [CNT_W-1:0] wInc;
  logic [CNT_W-1:0] rInc;
  logic [CNT_W-1:0] nOfs;
  logic [CNT_W-1:0] mOfs;
  logic [CNT_W-1:0] dep;
  logic [CNT_W-1:0] aeU   [NUM_QUEUES];
  logic [CNT_W-1:0] afU   [NUM_QUEUES];
  logic [CNT_W-1:0] fullU [NUM_QUEUES];
  logic             wrAcc;
  logic             rdAcc;
  logic [1:0]       wrQ_nxt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      defSel_r  <= defaultOffsetSelect;
      busMode_r <= flagBusModeSelect;
      master_r  <= chainMasterSelect;
    end
  end

  // ---------------- register bus slave ----------------
  assign waitrequest = (read | write) & ~ack_r;
  assign readdata    = readdata_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (read && !ack_r) begin
      case (address)
        OFS_CTRL:      readdata_r <= {29'h0, ctrl_r};
        OFS_STATUS:    readdata_r <= {2'h0, rdQ_r, 2'h0, wrQ_r, afBus_r, aeBus_r,
                                      2'h0, ownTok_r, ownAddr_r, queueFullN,
                                      almostFullN, almostEmptyN, 4'h0,
                                      master_r, busMode_r, 2'h0, defSel_r};
        OFS_AE_OFFSET: readdata_r <= {16'h0000, aeOfs_r};
        OFS_AF_OFFSET: readdata_r <= {16'h0000, afOfs_r};
        OFS_DEPTH:     readdata_r <= {16'h0000, depth_r};
        default:       readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r  <= CTRL_RST;
      aeOfs_r <= AE_OFFSET_RST;
      afOfs_r <= AF_OFFSET_RST;
      depth_r <= DEPTH_RST;
    end else if (write && ack_r) begin
      case (address)
        OFS_CTRL:      ctrl_r  <= writedata[2:0];
        OFS_AE_OFFSET: aeOfs_r <= writedata[15:0];
        OFS_AF_OFFSET: afOfs_r <= writedata[15:0];
        OFS_DEPTH:     depth_r <= writedata[15:0];
        default:       ;
      endcase
    end
  end

  // ---------------- offsets and boundaries ----------------
  assign match = mqfg_match_t'(ctrl_r[CTRL_MATCH_LSB +: 2]);
  assign wInc  = (match == MQFG_M18_9) ? CNT_W'(2) : CNT_W'(1);
  assign rInc  = (match == MQFG_M9_18) ? CNT_W'(2) : CNT_W'(1);
  assign dep   = {4'h0, depth_r};

  always_comb begin
    if (ctrl_r[CTRL_DEFAULTS_BIT]) begin
      nOfs = {4'h0, defSel_r ? DEFAULT_OFFSET_HIGH : DEFAULT_OFFSET_LOW};
      mOfs = {4'h0, defSel_r ? DEFAULT_OFFSET_HIGH : DEFAULT_OFFSET_LOW};
    end else begin
      nOfs = {4'h0, aeOfs_r};
      mOfs = {4'h0, afOfs_r};
    end
  end

  // limits are counted in writes (in reads for MQFG_M9_18), then scaled into storage units
  always_comb begin
    logic [CNT_W-1:0] aeW;
    logic [CNT_W-1:0] afW;
    logic [CNT_W-1:0] fW;
    logic [CNT_W-1:0] room;
    aeW  = '0;
    afW  = '0;
    fW   = '0;
    room = (mOfs > dep) ? '0 : dep - mOfs;
    for (int q = 0; q < NUM_QUEUES; q++) begin
      case (match)
        MQFG_M18_9: begin
          aeW = nOfs + CNT_W'(1);
          afW = room;
          fW  = dep;
        end
        MQFG_M9_18: begin
          aeW = shared_r[q] ? (nOfs + CNT_W'(2)) << 1 : (nOfs + CNT_W'(1)) << 1;
          afW = (room + CNT_W'(1)) << 1;
          fW  = shared_r[q] ? (dep + CNT_W'(1)) << 1 : dep << 1;
        end
        default: begin
          aeW = shared_r[q] ? nOfs + CNT_W'(2) : nOfs + CNT_W'(1);
          afW = shared_r[q] ? room + CNT_W'(1) : room;
          fW  = shared_r[q] ? dep + CNT_W'(1) : dep;
        end
      endcase
      aeU[q]   = (wInc == CNT_W'(2)) ? aeW << 1 : aeW;
      afU[q]   = (wInc == CNT_W'(2)) ? afW << 1 : afW;
      fullU[q] = (wInc == CNT_W'(2)) ? fW << 1 : fW;
    end
  end

  // ---------------- queue selection and occupancy ----------------
  assign wrQ_nxt = writeQueueLoad ? writeQueueAddress[1:0] : wrQ_r;
  assign wrAcc   = writeEnable & ~fullRaw[wrQ_r];
  assign rdAcc   = readEnable & (occ_r[rdQ_r] >= rInc);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrQ_r <= 2'h0;
      rdQ_r <= 2'h0;
    end else begin
      wrQ_r <= wrQ_nxt;
      if (readQueueLoad) begin
        rdQ_r <= readQueueAddress;
      end
    end
  end

  always_comb begin
    for (int q = 0; q < NUM_QUEUES; q++) begin
      occ_nxt[q] = occ_r[q];
      if (wrAcc && wrQ_r == 2'(q)) begin
        occ_nxt[q] = occ_nxt[q] + wInc;
      end
      if (rdAcc && rdQ_r == 2'(q)) begin
        occ_nxt[q] = occ_nxt[q] - rInc;
      end
      aeRaw[q]   = occ_r[q] >= aeU[q];
      afRaw[q]   = occ_r[q] < afU[q];
      fullNxt[q] = occ_nxt[q] >= fullU[q];
    end
  end

  // kept apart so the write accept does not feed back into the process above
  always_comb begin
    for (int q = 0; q < NUM_QUEUES; q++) begin
      fullRaw[q] = occ_r[q] >= fullU[q];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        occ_r[q] <= '0;
      end
      shared_r <= 4'h0;
    end else begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        occ_r[q] <= occ_nxt[q];
        // sharing is fixed by where the read port sits at the first word
        if (wrAcc && wrQ_r == 2'(q) && occ_r[q] == '0) begin
          shared_r[q] <= (rdQ_r == 2'(q));
        end
      end
    end
  end

  // ---------------- flag timing ----------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fullN_r <= 1'b1;
    end else begin
      fullN_r <= ~fullNxt[wrQ_nxt];
    end
  end

  // rise follows one edge after the cause, fall needs two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aeDly_r <= 4'h0;
      aeBus_r <= 4'h0;
      afDly_r <= 4'hF;
      afBus_r <= 4'hF;
    end else begin
      aeDly_r <= aeRaw;
      aeBus_r <= aeRaw | aeDly_r;
      afDly_r <= afRaw;
      afBus_r <= afRaw | afDly_r;
    end
  end

  assign queueFullN     = fullN_r;
  assign almostEmptyN   = aeBus_r[rdQ_r];
  assign almostFullN    = afBus_r[wrQ_r];
  assign almostEmptyBus = aeBus_r;
  assign almostFullBus  = afBus_r;

  // ---------------- shared almost-full bus ----------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ownAddr_r <= 1'b0;
    end else if (!busMode_r && fullBusSelectStrobe) begin
      ownAddr_r <= (writeQueueAddress[4:2] == deviceId);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tokFirst_r <= 1'b1;
      ownTok_r   <= 1'b0;
    end else begin
      tokFirst_r <= 1'b0;
      ownTok_r   <= busMode_r & ((tokFirst_r & master_r) | fullTokenIn);
    end
  end

  assign almostFullBusOe = busMode_r ? ownTok_r : ownAddr_r;
  assign fullTokenOut    = ownTok_r;

  // ---------------- checks ----------------
  sequence s_fall2(sig, out);
    $fell(sig) ##1 !sig;
  endsequence

  property p_full_on_write;
    @(posedge clk_sys) disable iff (rst)
      (wrAcc && !writeQueueLoad && fullNxt[wrQ_r]) |=> !queueFullN;
  endproperty
  a_full_on_write: assert property (p_full_on_write)
    else $error("full flag missed the filling write");

  property p_full_release;
    @(posedge clk_sys) disable iff (rst)
      (!writeQueueLoad && !fullNxt[wrQ_r]) |=> queueFullN;
  endproperty
  a_full_release: assert property (p_full_release)
    else $error("full flag did not return high");

  property p_ae_fall;
    @(posedge clk_sys) disable iff (rst)
      s_fall2(aeRaw[0], almostEmptyBus[0]) |=> !almostEmptyBus[0];
  endproperty
  a_ae_fall: assert property (p_ae_fall)
    else $error("almost-empty bus bit fall not two clocks");

  property p_ae_hold;
    @(posedge clk_sys) disable iff (rst)
      $fell(aeRaw[0]) |=> almostEmptyBus[0];
  endproperty
  a_ae_hold: assert property (p_ae_hold)
    else $error("almost-empty fell too early");

  property p_ae_rise;
    @(posedge clk_sys) disable iff (rst)
      $rose(aeRaw[0]) |=> almostEmptyBus[0];
  endproperty
  a_ae_rise: assert property (p_ae_rise)
    else $error("almost-empty did not rise after one clock");

  property p_af_fall;
    @(posedge clk_sys) disable iff (rst)
      $fell(afRaw[0]) |=> almostFullBus[0] ##1 (!almostFullBus[0] || $past(afRaw[0]));
  endproperty
  a_af_fall: assert property (p_af_fall)
    else $error("almost-full bus bit fall not two clocks");

  property p_af_rise;
    @(posedge clk_sys) disable iff (rst)
      $rose(afRaw[0]) |=> almostFullBus[0];
  endproperty
  a_af_rise: assert property (p_af_rise)
    else $error("almost-full did not rise after one clock");

  property p_addr_select;
    @(posedge clk_sys) disable iff (rst)
      (!busMode_r && fullBusSelectStrobe && writeQueueAddress[4:2] == deviceId)
        |=> almostFullBusOe;
  endproperty
  a_addr_select: assert property (p_addr_select)
    else $error("addressed select not shown one clock later");

  property p_token_master;
    @(posedge clk_sys) disable iff (rst)
      (tokFirst_r && busMode_r && master_r) |=> (fullTokenOut && almostFullBusOe);
  endproperty
  a_token_master: assert property (p_token_master)
    else $error("master did not take the bus first");

  property p_addr_release;
    @(posedge clk_sys) disable iff (rst)
      (!busMode_r && fullBusSelectStrobe && writeQueueAddress[4:2] != deviceId)
        |=> !almostFullBusOe;
  endproperty
  a_addr_release: assert property (p_addr_release)
    else $error("addressed release not shown one clock later");

  property p_token_pass;
    @(posedge clk_sys) disable iff (rst)
      (busMode_r && fullTokenIn) |=> (fullTokenOut && almostFullBusOe);
  endproperty
  a_token_pass: assert property (p_token_pass)
    else $error("token input did not hand over the bus");

  property p_default_ofs;
    @(posedge clk_sys) disable iff (rst)
      (ctrl_r[CTRL_DEFAULTS_BIT] && !defSel_r) |-> (nOfs == CNT_W'(8) && mOfs == CNT_W'(8));
  endproperty
  a_default_ofs: assert property (p_default_ofs)
    else $error("default offset wrong");

endmodule : mqfg_flag_gen

// ===== bench/mqfg_host_model.sv
`timescale 1ns/1ps
module mqfg_host_model (
  input  wire logic       clk_sys,
  output logic            writeEnable,
  output logic      [4:0] writeQueueAddress,
  output logic            writeQueueLoad,
  output logic            readEnable,
  output logic      [1:0] readQueueAddress,
  output logic            readQueueLoad,
  output logic            fullBusSelectStrobe
);
  initial begin
    {writeEnable, writeQueueLoad, readEnable, readQueueLoad, fullBusSelectStrobe} = 5'h00;
    writeQueueAddress = 5'h00;
    readQueueAddress  = 2'h0;
  end
  // n writes, spaced by gap idle cycles; returns at the edge taking the last
  task automatic put(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      if (i > 0 && gap > 0) begin
        @(posedge clk_sys);
        writeEnable <= 1'b0;
        repeat (gap - 1) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      writeEnable <= 1'b1;
    end
    @(posedge clk_sys);
    writeEnable <= 1'b0;
  endtask : put
  task automatic get(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      readEnable <= 1'b1;
    end
    @(posedge clk_sys);
    readEnable <= 1'b0;
  endtask : get
  // queue load and bus select never share a cycle
  task automatic selw(input logic [4:0] a, input logic bus);
    @(posedge clk_sys);
    writeQueueAddress   <= a;
    writeQueueLoad      <= !bus;
    fullBusSelectStrobe <= bus;
    @(posedge clk_sys);
    writeQueueLoad      <= 1'b0;
    fullBusSelectStrobe <= 1'b0;
  endtask : selw
  task automatic selr(input logic [1:0] q);
    @(posedge clk_sys);
    readQueueAddress <= q;
    readQueueLoad    <= 1'b1;
    @(posedge clk_sys);
    readQueueLoad    <= 1'b0;
  endtask : selr
endmodule : mqfg_host_model

// ===== bench/mqfg_flag_gen_tb_top.sv
`timescale 1ns/1ps
module mqfg_flag_gen_tb_top import mqfg_pkg::*;;
  logic        clk_sys, rst, read, write, defaultOffsetSelect, flagBusModeSelect;
  logic        chainMasterSelect, fullTokenIn, waitrequest, fullBusSelectStrobe;
  logic        writeEnable, writeQueueLoad, readEnable, readQueueLoad;
  logic        queueFullN, almostEmptyN, almostFullN, almostFullBusOe, fullTokenOut;
  logic [4:0]  address, writeQueueAddress;
  logic [1:0]  readQueueAddress;
  logic [31:0] writedata, readdata, rdat;
  logic [3:0]  almostEmptyBus, almostFullBus;
  logic [2:0]  deviceId;
  logic [31:0] lfsrState;
  int          badCount, checks, cyc, n, lim;
  mqfg_match_t modeT [6] = '{MQFG_M18_18, MQFG_M9_9, MQFG_M18_9, MQFG_M9_18, MQFG_M18_18,
                             MQFG_M9_18};
  int          sharedT [6] = '{1, 1, 1, 1, 0, 0};
  int          defT [6] = '{2, 1, 0, 0, 0, 0};

  mqfg_flag_gen DUT (.*);
  mqfg_host_model host (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address   <= a;
    read      <= rd;
    write     <= !rd;
    writedata <= d;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rdat = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : av

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic do_reset(input logic df, input logic fm, input logic ms);
    @(posedge clk_sys);
    defaultOffsetSelect <= df;
    flagBusModeSelect   <= fm;
    chainMasterSelect   <= ms;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      badCount++;
      print_verdict;
    end
  end

  initial begin
    {rst, read, write, defaultOffsetSelect, flagBusModeSelect} = 5'h10;
    {chainMasterSelect, fullTokenIn} = 2'h0;
    address = 5'h00;
    writedata = 32'h0;
    deviceId = 3'h5;
    lfsrState = 32'h1119;
    {badCount, checks, cyc} = 0;
    do_reset(1'b0, 1'b0, 1'b0);
    settle(1);
    chk("fullN", 1, queueFullN);
    chk("aeBus", 0, almostEmptyBus);
    chk("oe", 0, almostFullBusOe);
    av(1'b1, OFS_CTRL, 32'h0);
    chk("ctrl", CTRL_RST, rdat);
    av(1'b1, 5'h14, 32'h0);
    chk("unmapped", 0, rdat);
    $display("test reset done");
    for (int c = 0; c < 6; c++) begin
      do_reset(defT[c] == 2, 1'b0, 1'b0);
      lfsrState = lfsr_step(lfsrState);
      n = (defT[c] == 2) ? 128 : (defT[c] == 1) ? 8 : int'(lfsrState % 24) + 1;
      av(1'b0, OFS_CTRL, {29'h0, defT[c] != 0, 2'(modeT[c])});
      if (defT[c] == 0) begin
        av(1'b0, OFS_AE_OFFSET, 32'(n));
        av(1'b1, OFS_AE_OFFSET, 32'h0);
        chk("aeOffset", 32'(n), rdat);
      end
      if (sharedT[c] == 0) host.selr(2'h1);
      if (modeT[c] == MQFG_M9_18) lim = sharedT[c] ? 2 * (n + 2) : 2 * (n + 1);
      else if (modeT[c] == MQFG_M18_9) lim = n + 1;
      else lim = sharedT[c] ? n + 2 : n + 1;
      host.put(lim - 1, c % 3);
      settle(2);
      chk("aeBus0", 0, almostEmptyBus[0]);
      host.put(1, 0);
      settle(1);
      chk("aeBus0", 1, almostEmptyBus[0]);
      if (sharedT[c] != 0) chk("aeN", 1, almostEmptyN);
      if (sharedT[c] != 0 && modeT[c] != MQFG_M18_9 && modeT[c] != MQFG_M9_18) begin
        host.get(1);
        settle(1);
        chk("aeN", 1, almostEmptyN);
        settle(1);
        chk("aeN", 0, almostEmptyN);
        chk("aeBus0", 0, almostEmptyBus[0]);
      end
      $display("test almost empty case %0d done", c);
    end
    do_reset(1'b0, 1'b0, 1'b0);
    av(1'b0, OFS_CTRL, 32'h0);
    av(1'b0, OFS_DEPTH, 32'h10);
    av(1'b0, OFS_AF_OFFSET, 32'h4);
    host.selw({3'h5, 2'b00}, 1'b1);
    settle(1);
    chk("oe", 1, almostFullBusOe);
    host.put(12, 0);
    settle(3);
    chk("afBus", 4'hF, almostFullBus);
    host.put(1, 0);
    settle(1);
    chk("afN", 1, almostFullN);
    settle(1);
    chk("afN", 0, almostFullN);
    chk("afBus", 4'hE, almostFullBus);
    host.put(3, 0);
    settle(1);
    chk("fullN", 1, queueFullN);
    host.put(1, 0);
    settle(0);
    chk("fullN", 0, queueFullN);
    host.put(1, 0);
    host.get(1);
    settle(1);
    chk("fullN", 1, queueFullN);
    host.selw({3'h5, 2'b01}, 1'b0);
    settle(1);
    chk("afN", 1, almostFullN);
    chk("afBus", 4'hE, almostFullBus);
    host.selw({3'h2, 2'b00}, 1'b1);
    settle(1);
    chk("oe", 0, almostFullBusOe);
    av(1'b1, OFS_STATUS, 32'h0);
    chk("status", 32'h01E0_0C00, rdat);
    host.get(4);
    settle(1);
    chk("afBus", 4'hF, almostFullBus);
    $display("test almost full done");
    do_reset(1'b0, 1'b1, 1'b1);
    settle(1);
    chk("token", 1, fullTokenOut);
    chk("oe", 1, almostFullBusOe);
    settle(1);
    chk("token", 0, fullTokenOut);
    @(posedge clk_sys);
    fullTokenIn <= 1'b1;
    @(posedge clk_sys);
    fullTokenIn <= 1'b0;
    #1;
    chk("token", 1, fullTokenOut);
    settle(1);
    chk("oe", 0, almostFullBusOe);
    $display("test polled done");
    print_verdict;
  end
endmodule : mqfg_flag_gen_tb_top
